// file: sysreg_pkg.sv
// Package for the system configuration and status register bank.
// Assumes a 16-bit peripheral bus addressed in bytes, LSB ignored.
package sysreg_pkg;

  // Register byte offsets on the peripheral bus
  localparam logic [15:0] ADDR_RSVD_LO   = 16'h7010;
  localparam logic [15:0] ADDR_RSVD_HI   = 16'h7016;
  localparam logic [15:0] ADDR_CONTROL   = 16'h7018;
  localparam logic [15:0] ADDR_STATUS    = 16'h701a;
  localparam logic [15:0] ADDR_RSVD_1C   = 16'h701c;
  localparam logic [15:0] ADDR_VECTOR    = 16'h701e;

  // Control register fields
  localparam int CTL_REQ_HI  = 15;
  localparam int CTL_REQ_LO  = 14;
  localparam int CTL_SEL_HI  = 7;
  localparam int CTL_SEL_LO  = 6;

  // Status register fields
  localparam int ST_POWER_ON = 15;
  localparam int ST_ILLEGAL  = 12;
  localparam int ST_SOFTWARE = 10;
  localparam int ST_WATCHDOG = 9;
  localparam int ST_OVERRIDE = 5;
  localparam int ST_ANALOG   = 3;
  localparam int ST_VECTOR   = 0;

  // Reset values
  localparam logic       REQ_HI_RESET  = 1'b0;
  localparam logic       REQ_LO_RESET  = 1'b1;
  localparam logic [1:0] SEL_POR_VALUE = 2'h3;
  localparam logic       ANALOG_RESET  = 1'b1;
  // Value returned from reserved bit positions
  localparam logic [15:0] RSVD_READ    = 16'h0000;

  // Clock output source select
  typedef enum logic [1:0] {
    CLOCK_OUTPUT_PIN_GPIO     = 2'h0,
    CLOCK_OUTPUT_PIN_WATCHDOG = 2'h1,
    CLOCK_OUTPUT_PIN_PERIPH   = 2'h2,
    CLOCK_OUTPUT_PIN_CPU      = 2'h3
  } clk_sel_t;

  // Peripheral bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pbus_req_t;

  // Reset cause flags, each held once set
  typedef struct packed {
    logic powerOn;
    logic illegal;
    logic software;
    logic watchdog;
  } cause_t;

endpackage : sysreg_pkg

// file: sync2.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the input changes slowly relative to clk_sys.
module sync2 (
  input  wire logic clk_sys,   // System clock
  input  wire logic reset,     // Synchronous reset, active high
  input  wire logic asyncIn,   // Level from a pin
  output logic      syncOut    // Level in the clk_sys domain
);
  logic meta_r, meta_nxt, sync_r, sync_nxt;

  // Stage one feeds only stage two
  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;
endmodule : sync2

// file: clock_output_pin_mux.sv
// Registered selector for the clock output pin source.
// Assumes the source clocks arrive as levels already sampled in clk_sys.
module clock_output_pin_mux
  import sysreg_pkg::*;
(
  input  wire logic     clk_sys,      // System clock
  input  wire logic     reset,        // Synchronous reset, active high
  input  wire clk_sel_t sel,          // Source select
  input  wire logic     gpioLevel,    // Digital I/O level
  input  wire logic     wdClkLevel,   // Watchdog clock level
  input  wire logic     perClkLevel,  // Peripheral clock level
  input  wire logic     cpuClkLevel,  // Processor clock level
  output logic          pinOut        // Registered pin level
);
  logic pin_r, pin_nxt;

  // Source mux; registered so the pin never glitches on a select change
  always_comb begin
    unique case (sel)
      CLOCK_OUTPUT_PIN_GPIO:     pin_nxt = gpioLevel;
      CLOCK_OUTPUT_PIN_WATCHDOG: pin_nxt = wdClkLevel;
      CLOCK_OUTPUT_PIN_PERIPH:   pin_nxt = perClkLevel;
      CLOCK_OUTPUT_PIN_CPU:      pin_nxt = cpuClkLevel;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) pin_r <= 1'b0;
    else pin_r <= pin_nxt;
  end

  assign pinOut = pin_r;
endmodule : clock_output_pin_mux

// file: system_config_status_regs.sv
// System configuration register bank: control, status and vector registers.
// Assumes a single-cycle peripheral bus on clk_sys, reset is the global reset
// and powerOnReset is the power-on reset, both synchronous and active high.
module system_config_status_regs
  import sysreg_pkg::*;
(
  input  wire logic        clk_sys,           // System clock, 100 MHz
  input  wire logic        reset,             // Global reset, active high
  input  wire logic        powerOnReset,      // Power-on reset, active high
  input  wire pbus_req_t   busReq,            // Peripheral bus request
  output logic [15:0]      busRdata,          // Registered read data
  input  wire logic        illegalAccess,     // Illegal address access pulse
  input  wire logic        watchdogOverflow,  // Watchdog overflow pulse
  input  wire logic        flashSupplyPin,    // Programming supply at 5V
  input  wire logic        analogFault,       // Analog supply fault pin
  input  wire logic        vectorLoad,        // Interrupt acknowledge pulse
  input  wire logic [7:0]  vectorIn,          // Vector offset from peripheral
  input  wire logic        gpioLevel,         // Digital I/O level for pin
  input  wire logic        wdClkLevel,        // Watchdog clock level
  input  wire logic        perClkLevel,       // Peripheral clock level
  input  wire logic        cpuClkLevel,       // Processor clock level
  output logic             clockOutputPin,    // Clock output pin
  output logic             globalResetReq,    // Request for global reset
  output logic             flashProgEnable,   // Flash programming allowed
  output logic             watchdogDisableOk  // Watchdog may be disabled
);

  // Decode a bus address ignoring bit zero
  function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
    hit = (a[15:1] == base[15:1]);
  endfunction : hit

  logic        supplySync, analogSync;
  logic        wrCtl, wrSt, rdVec, rdCtl, rdSt;
  logic        swResetWr;
  logic        reqHi_r, reqHi_nxt, reqLo_r, reqLo_nxt;
  logic [1:0]  sel_r, sel_nxt;
  cause_t      cause_r, cause_nxt;
  logic        pendCause_r, pendCause_nxt;
  cause_t      pendKind_r, pendKind_nxt;
  logic        override_r, override_nxt;
  logic        inReset_r, inReset_nxt;
  logic        analog_r, analog_nxt;
  logic        vecPend_r, vecPend_nxt;
  logic [7:0]  vec_r, vec_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        gReq_r, gReq_nxt;
  logic        flash_r, flash_nxt, wdOk_r, wdOk_nxt;
  logic [15:0] statusWord;

  // Pin levels enter through two flops
  sync2 u_supplySync (
    .clk_sys (clk_sys),
    .reset   (1'b0),
    .asyncIn (flashSupplyPin),
    .syncOut (supplySync)
  );
  sync2 u_analogSync (
    .clk_sys (clk_sys),
    .reset   (1'b0),
    .asyncIn (analogFault),
    .syncOut (analogSync)
  );

  // Access decode; reserved locations decode to nothing
  always_comb begin
    wrCtl = busReq.wr && hit(busReq.addr, ADDR_CONTROL);
    wrSt  = busReq.wr && hit(busReq.addr, ADDR_STATUS);
    rdCtl = busReq.rd && hit(busReq.addr, ADDR_CONTROL);
    rdSt  = busReq.rd && hit(busReq.addr, ADDR_STATUS);
    rdVec = busReq.rd && hit(busReq.addr, ADDR_VECTOR);
    // Any pair other than 01 resets
    swResetWr = wrCtl && (busReq.wdata[CTL_REQ_HI] || !busReq.wdata[CTL_REQ_LO]);
  end

  // Control register; select field is held over global reset
  always_comb begin
    reqHi_nxt = reqHi_r;
    reqLo_nxt = reqLo_r;
    sel_nxt   = sel_r;
    if (wrCtl) begin
      reqHi_nxt = busReq.wdata[CTL_REQ_HI];
      reqLo_nxt = busReq.wdata[CTL_REQ_LO];
      sel_nxt   = busReq.wdata[CTL_SEL_HI:CTL_SEL_LO];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (powerOnReset) begin
      sel_r <= SEL_POR_VALUE;
    end else begin
      sel_r <= sel_nxt;
    end
    if (powerOnReset || reset) begin
      reqHi_r <= REQ_HI_RESET;
      reqLo_r <= REQ_LO_RESET;
    end else begin
      reqHi_r <= reqHi_nxt;
      reqLo_r <= reqLo_nxt;
    end
  end

  // Cause flags. A reset cause is set on the same edge that requests the reset,
  // and kept in pendKind_r to be ORed back during reset so it survives the reset itself.
  always_comb begin
    cause_nxt     = cause_r;
    pendKind_nxt  = pendKind_r;
    pendCause_nxt = pendCause_r;
    if (wrSt) begin
      // Write one clears, zero keeps
      if (busReq.wdata[ST_POWER_ON]) cause_nxt.powerOn  = 1'b0;
      if (busReq.wdata[ST_ILLEGAL])  cause_nxt.illegal  = 1'b0;
      if (busReq.wdata[ST_SOFTWARE]) cause_nxt.software = 1'b0;
      if (busReq.wdata[ST_WATCHDOG]) cause_nxt.watchdog = 1'b0;
    end
    if (illegalAccess)    pendKind_nxt.illegal  = 1'b1;
    if (swResetWr)        pendKind_nxt.software = 1'b1;
    if (watchdogOverflow) pendKind_nxt.watchdog = 1'b1;
    if (illegalAccess || swResetWr || watchdogOverflow) pendCause_nxt = 1'b1;
    // Set wins over a clear in the same cycle
    cause_nxt = cause_nxt | pendKind_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (powerOnReset) begin
      cause_r     <= '{powerOn: 1'b1, default: 1'b0};
      pendKind_r  <= '0;
      pendCause_r <= 1'b0;
    end else if (reset) begin
      cause_r     <= cause_r | pendKind_r;
      pendKind_r  <= '0;
      pendCause_r <= 1'b0;
    end else begin
      cause_r     <= cause_nxt;
      pendKind_r  <= pendKind_nxt;
      pendCause_r <= pendCause_nxt;
    end
  end

  // Override flag, analog fault mirror and vector holding
  always_comb begin
    inReset_nxt  = reset || powerOnReset;
    override_nxt = override_r;
    // Software clear first, so a set at reset release wins in the same cycle
    if (wrSt && busReq.wdata[ST_OVERRIDE]) override_nxt = 1'b0;
    if (inReset_r && !inReset_nxt && supplySync) override_nxt = 1'b1;
    if (!supplySync) override_nxt = 1'b0;
    analog_nxt  = analogSync;
    vec_nxt     = vectorLoad ? vectorIn : vec_r;
    vecPend_nxt = vecPend_r;
    if (rdVec) vecPend_nxt = 1'b0;
    if (vectorLoad) vecPend_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    inReset_r <= inReset_nxt;
    if (reset || powerOnReset) begin
      override_r <= 1'b0;
      analog_r   <= ANALOG_RESET;
      vecPend_r  <= 1'b0;
      vec_r      <= 8'h00;
    end else begin
      override_r <= override_nxt;
      analog_r   <= analog_nxt;
      vecPend_r  <= vecPend_nxt;
      vec_r      <= vec_nxt;
    end
  end

  // Status word image; reserved bits read as zero
  always_comb begin
    statusWord              = RSVD_READ;
    statusWord[ST_POWER_ON] = cause_r.powerOn;
    statusWord[ST_ILLEGAL]  = cause_r.illegal;
    statusWord[ST_SOFTWARE] = cause_r.software;
    statusWord[ST_WATCHDOG] = cause_r.watchdog;
    statusWord[ST_OVERRIDE] = override_r;
    statusWord[ST_ANALOG]   = analog_r;
    statusWord[ST_VECTOR]   = vecPend_r;
  end

  // Read data and registered outputs
  always_comb begin
    rdata_nxt = RSVD_READ;
    if (rdCtl) begin
      rdata_nxt[CTL_REQ_HI]            = reqHi_r;
      rdata_nxt[CTL_REQ_LO]            = reqLo_r;
      rdata_nxt[CTL_SEL_HI:CTL_SEL_LO] = sel_r;
    end else if (rdSt) begin
      rdata_nxt = statusWord;
    end else if (rdVec) begin
      rdata_nxt = {8'h00, vec_r};
    end
    gReq_nxt  = swResetWr || illegalAccess || watchdogOverflow;
    flash_nxt = override_r;
    wdOk_nxt  = override_r;
  end

  always_ff @(posedge clk_sys) begin
    if (reset || powerOnReset) begin
      rdata_r <= 16'h0000;
      gReq_r  <= 1'b0;
      flash_r <= 1'b0;
      wdOk_r  <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      gReq_r  <= gReq_nxt;
      flash_r <= flash_nxt;
      wdOk_r  <= wdOk_nxt;
    end
  end

  clock_output_pin_mux u_clock_output_pin (
    .clk_sys     (clk_sys),
    .reset       (1'b0),
    .sel         (clk_sel_t'(sel_r)),
    .gpioLevel   (gpioLevel),
    .wdClkLevel  (wdClkLevel),
    .perClkLevel (perClkLevel),
    .cpuClkLevel (cpuClkLevel),
    .pinOut      (clockOutputPin)
  );

  assign busRdata          = rdata_r;
  assign globalResetReq    = gReq_r;
  assign flashProgEnable   = flash_r;
  assign watchdogDisableOk = wdOk_r;

  // Checks kept beside the logic
  sw_reset_req_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    swResetWr |=> globalResetReq)
    else $error("software reset write did not request reset");
  no_reset_01_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    (wrCtl && !busReq.wdata[CTL_REQ_HI] && busReq.wdata[CTL_REQ_LO] && !illegalAccess && !watchdogOverflow)
    |=> !globalResetReq)
    else $error("write of 01 requested a reset");
  sel_hold_a: assert property (@(posedge clk_sys) disable iff (powerOnReset)
    (reset && !wrCtl) |=> sel_r == $past(sel_r))
    else $error("select changed on global reset");
  por_sel_a: assert property (@(posedge clk_sys)
    powerOnReset |=> sel_r == SEL_POR_VALUE && cause_r.powerOn)
    else $error("power-on reset values wrong");
  sw_cause_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    swResetWr |=> cause_r.software)
    else $error("software cause not recorded");
  wd_cause_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    watchdogOverflow |=> cause_r.watchdog)
    else $error("watchdog cause not recorded");
  vec_pend_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    vectorLoad |=> vecPend_r)
    else $error("vector pending not set");
  vec_clear_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    (rdVec && !vectorLoad) |=> !vecPend_r)
    else $error("vector read did not clear pending");
  vec_upper_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    rdVec |=> busRdata[15:8] == 8'h00)
    else $error("vector upper byte not zero");
  override_drop_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    !supplySync |=> !override_r ##2 !flashProgEnable)
    else $error("override held without supply");
  alias_read_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    (busReq.rd && busReq.addr == (ADDR_STATUS | 16'h0001)) |=> busRdata == $past(statusWord))
    else $error("odd alias did not read status");
  ill_cause_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    illegalAccess |=> cause_r.illegal && globalResetReq)
    else $error("illegal access not recorded");
  cause_keep_a: assert property (@(posedge clk_sys) disable iff (powerOnReset)
    (reset && cause_r.software) |=> cause_r.software)
    else $error("software cause lost over reset");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    (wrSt && busReq.wdata[ST_WATCHDOG] && watchdogOverflow) |=> cause_r.watchdog)
    else $error("clear beat a watchdog set");
  override_set_a: assert property (@(posedge clk_sys) disable iff (powerOnReset)
    (inReset_r && !reset && supplySync) |=> override_r)
    else $error("override not latched at reset end");
  flash_follow_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    override_r |=> flashProgEnable && watchdogDisableOk)
    else $error("override did not enable flash and watchdog disable");
  analog_reset_a: assert property (@(posedge clk_sys)
    (reset || powerOnReset) |=> analog_r)
    else $error("analog fault flag not one in reset");
  rsvd_read_a: assert property (@(posedge clk_sys) disable iff (reset || powerOnReset)
    (busReq.rd && !rdCtl && !rdSt && !rdVec) |=> busRdata == RSVD_READ)
    else $error("reserved location read not zero");

endmodule : system_config_status_regs

// file: system_config_status_regs_tb.sv
// Self-checking bench for the system configuration register bank.
// Assumes the bank's own assertions run inside it; the bench drives every port itself.
module system_config_status_regs_tb;
  import sysreg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys;
  logic        reset;
  logic        powerOnReset;
  pbus_req_t   busReq;
  logic [15:0] busRdata;
  logic [2:0]  evts;         // {illegal, watchdog, vector load}
  logic        flashSupplyPin;
  logic        analogFault;
  logic [7:0]  vectorIn;
  logic [3:0]  srcLv;        // {cpu, peripheral, watchdog, gpio}
  logic        clockOutputPin;
  logic        globalResetReq;
  logic        flashProgEnable;
  logic        watchdogDisableOk;
  int          numErrors;
  int          testsRun;

  system_config_status_regs system_config_status_regs_inst (
    .clk_sys           (clk_sys),
    .reset             (reset),
    .powerOnReset      (powerOnReset),
    .busReq            (busReq),
    .busRdata          (busRdata),
    .illegalAccess     (evts[2]),
    .watchdogOverflow  (evts[1]),
    .flashSupplyPin    (flashSupplyPin),
    .analogFault       (analogFault),
    .vectorLoad        (evts[0]),
    .vectorIn          (vectorIn),
    .gpioLevel         (srcLv[0]),
    .wdClkLevel        (srcLv[1]),
    .perClkLevel       (srcLv[2]),
    .cpuClkLevel       (srcLv[3]),
    .clockOutputPin    (clockOutputPin),
    .globalResetReq    (globalResetReq),
    .flashProgEnable   (flashProgEnable),
    .watchdogDisableOk (watchdogDisableOk)
  );

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // Counts, then the single verdict of the run
  task wrap_up;
    $display("checks %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One bus cycle, optionally with event pulses in the same cycle; ends just after the taking edge
  task bus(input logic r, input logic w, input logic [15:0] a, input logic [15:0] d, input logic [2:0] e);
    @(posedge clk_sys);
    busReq <= '{r, w, a, d};
    evts   <= e;
    @(posedge clk_sys);
    busReq <= '{1'b0, 1'b0, 16'h0000, 16'h0000};
    evts   <= 3'h0;
    #1;
  endtask : bus

  task rd(input logic [15:0] a, input logic [15:0] exp);
    bus(1'b1, 1'b0, a, 16'h0000, 3'h0);
    check(busRdata, exp, "read data");
  endtask : rd

  task wr(input logic [15:0] a, input logic [15:0] d);
    bus(1'b0, 1'b1, a, d, 3'h0);
  endtask : wr

  // Pulses seen on the reset request over the three cycles after an access
  task count_req(input int exp);
    int n;
    n = 0;
    repeat (3) begin
      if (globalResetReq === 1'b1) n++;
      @(posedge clk_sys);
      #1;
    end
    check(16'(n), 16'(exp), "reset request pulses");
  endtask : count_req

  // The loop from reset request back to reset is closed here, reset held high for three cycles; the synchronisers never see it
  task greset;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : greset

  task por;
    @(posedge clk_sys);
    reset        <= 1'b1;
    powerOnReset <= 1'b1;
    repeat (12) @(posedge clk_sys);
    reset        <= 1'b0;
    powerOnReset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : por

  task wait_cy(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cy

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #200us;
    numErrors++;
    wrap_up();
  end

  initial begin
    logic [15:0] rsv [6];
    int          c;
    rsv = '{16'h7010, 16'h7012, 16'h7014, 16'h7016, 16'h701c, 16'h7011};
    clk_sys = 1'b0; reset = 1'b1; powerOnReset = 1'b1; busReq = '0; evts = 3'h0;
    flashSupplyPin = 1'b0; analogFault = 1'b0; vectorIn = 8'h00; srcLv = 4'h0;
    numErrors = 0; testsRun = 0;
    por();
    rd(ADDR_CONTROL, 16'h40c0);
    rd(ADDR_STATUS, 16'h8000);
    rd(16'h701b, 16'h8000);
    check(busRdata, 16'h8000, "read data");
    wait_cy(1);
    check(busRdata, 16'h0000, "idle data");
    $display("test reset values done");
    // Reserved places and reserved bits
    foreach (rsv[i]) begin
      wr(rsv[i], 16'hffff);
      rd(rsv[i], RSVD_READ);
    end
    wr(16'h7019, 16'h7fff);
    rd(ADDR_CONTROL, 16'h40c0);
    $display("test reserved done");
    // Every clock output source, each seen both high and low
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CONTROL, 16'h4000 | 16'(s << 6));
      rd(ADDR_CONTROL, 16'h4000 | 16'(s << 6));
      srcLv <= 4'h1 << s;
      wait_cy(3);
      check(clockOutputPin, 16'h0001, "clock pin high");
      srcLv <= 4'hf ^ (4'h1 << s);
      wait_cy(3);
      check(clockOutputPin, 16'h0000, "clock pin low");
    end
    $display("test clock output done");
    // Vector load, read clears, load beats read, writes ignored
    vectorIn <= 8'h5a;
    bus(1'b0, 1'b0, 16'h0000, 16'h0000, 3'h1);
    rd(ADDR_STATUS, 16'h8001);
    rd(16'h701f, 16'h005a);
    rd(ADDR_STATUS, 16'h8000);
    wr(ADDR_VECTOR, 16'hffff);
    rd(ADDR_VECTOR, 16'h005a);
    bus(1'b1, 1'b0, ADDR_VECTOR, 16'h0000, 3'h1);
    rd(ADDR_STATUS, 16'h8001);
    rd(ADDR_VECTOR, 16'h005a);
    $display("test vector done");
    // Software reset codes; select survives global reset
    for (int k = 0; k < 4; k++) begin
      c = (k == 3) ? 1 : ((k == 0) ? 0 : k + 1);
      wr(ADDR_CONTROL, 16'(c << 14) | 16'h0080);
      count_req((c == 1) ? 0 : 1);
      if (c != 1) begin
        greset();
        rd(ADDR_STATUS, 16'h8400);
        rd(ADDR_CONTROL, 16'h4080);
      end
    end
    wr(ADDR_STATUS, 16'h0000);
    rd(ADDR_STATUS, 16'h8400);
    wr(ADDR_STATUS, 16'h8400);
    rd(ADDR_STATUS, 16'h0000);
    $display("test software reset done");
    // Illegal access and watchdog causes; set beats clear
    bus(1'b0, 1'b0, 16'h0000, 16'h0000, 3'h4);
    count_req(1);
    bus(1'b0, 1'b0, 16'h0000, 16'h0000, 3'h2);
    count_req(1);
    greset();
    rd(ADDR_STATUS, 16'h1200);
    bus(1'b0, 1'b1, ADDR_STATUS, 16'h1200, 3'h2);
    count_req(1);
    rd(ADDR_STATUS, 16'h0200);
    greset();
    wr(ADDR_STATUS, 16'h1200);
    rd(ADDR_STATUS, 16'h0000);
    $display("test event causes done");
    // Override latched at reset end, cleared by software or supply drop
    flashSupplyPin <= 1'b1;
    wait_cy(4);
    greset();
    rd(ADDR_STATUS, 16'h0020);
    check(flashProgEnable, 16'h0001, "flash enable");
    check(watchdogDisableOk, 16'h0001, "wd disable");
    wr(ADDR_STATUS, 16'h0020);
    wait_cy(2);
    rd(ADDR_STATUS, 16'h0000);
    check(flashProgEnable, 16'h0000, "flash enable");
    greset();
    rd(ADDR_STATUS, 16'h0020);
    flashSupplyPin <= 1'b0;
    wait_cy(5);
    rd(ADDR_STATUS, 16'h0000);
    check(watchdogDisableOk, 16'h0000, "wd disable");
    analogFault <= 1'b1;
    wait_cy(5);
    rd(ADDR_STATUS, 16'h0008);
    $display("test override and analog done");
    // Power-on reset forces select to ones and sets only its own cause
    wr(ADDR_CONTROL, 16'h4000);
    bus(1'b0, 1'b0, 16'h0000, 16'h0000, 3'h2);
    por();
    rd(ADDR_CONTROL, 16'h40c0);
    rd(ADDR_STATUS, 16'h8008);
    $display("test power-on done");
    wrap_up();
  end
endmodule : system_config_status_regs_tb
